// ---- rtl/ict_regs.svh ----
// Opcode bytes, field positions and cycle counts for instruction timing
`ifndef ICT_REGS_SVH
`define ICT_REGS_SVH

`define ICT_WORD_W 24
`define ICT_OPB_HI 23
`define ICT_OPB_LO 16
`define ICT_EXT_ZERO 8'h00

// First-word opcode bytes that select each timing class except the single-word default and the all-zero second word
`define ICT_OP_COND_BRANCH 8'h31
`define ICT_OP_BRANCH_ALWAYS 8'h37
`define ICT_OP_IND_CALL 8'h01
`define ICT_OP_IND_JUMP 8'h02
`define ICT_OP_TBL_RD 8'hba
`define ICT_OP_TBL_WR 8'hbb
`define ICT_OP_RETURN 8'h06
`define ICT_OP_RET_INT 8'h07
`define ICT_OP_SKIP 8'ha6
`define ICT_OP_TWO_CALL 8'h02
`define ICT_OP_TWO_GOTO 8'h04
`define ICT_OP_DOUBLE_MOVE 8'hbe

// Instruction cycles per class
`define ICT_CYC_SINGLE 2'd1
`define ICT_CYC_COND 2'd2
`define ICT_CYC_BRANCH 2'd2
`define ICT_CYC_INDIRECT 2'd2
`define ICT_CYC_TABLE 2'd2
`define ICT_CYC_RETURN 2'd3
`define ICT_CYC_RET_INT 2'd3
`define ICT_CYC_TWO_WORD 2'd2
`define ICT_CYC_DOUBLE_MOVE 2'd2
`define ICT_CYC_SKIP_ONE 2'd2
`define ICT_CYC_SKIP_TWO 2'd3

`endif

// ---- rtl/ict_pkg.sv ----
// Types shared by the instruction timing blocks
package ict_pkg;

    typedef enum logic [3:0] {
        ICT_C_EXT,
        ICT_C_SINGLE,
        ICT_C_COND,
        ICT_C_BRANCH,
        ICT_C_INDIRECT,
        ICT_C_TABLE,
        ICT_C_RETURN,
        ICT_C_RET_INT,
        ICT_C_SKIP,
        ICT_C_TWO_WORD,
        ICT_C_DOUBLE_MOVE
    } ict_class_t;

    typedef enum logic [2:0] {
        ICT_S_EXEC,
        ICT_S_EXT,
        ICT_S_SKIP,
        ICT_S_SKIP_EXT,
        ICT_S_NOP
    } ict_state_t;

    typedef struct packed {
        ict_state_t state;
        logic [1:0] left;
        logic [1:0] cyc;
        logic ready;
        logic valid;
        logic nop;
        logic bad;
        ict_class_t cls;
        logic [23:0] op;
        logic [23:0] ext;
    } ict_core_t;

endpackage

// ---- rtl/ict_decode.sv ----
// Maps a fetched first word onto its timing class
`timescale 1ns/1ps
`include "ict_regs.svh"

module ict_decode
    import ict_pkg::*;
(
    input wire logic [23:0] word_i,
    output ict_class_t cls_o
);

    logic [7:0] opb;

    assign opb = word_i[`ICT_OPB_HI:`ICT_OPB_LO];

    always_comb begin
        case (opb)
            `ICT_EXT_ZERO: cls_o = ICT_C_EXT;
            `ICT_OP_COND_BRANCH: cls_o = ICT_C_COND;
            `ICT_OP_BRANCH_ALWAYS: cls_o = ICT_C_BRANCH;
            `ICT_OP_IND_CALL: cls_o = ICT_C_INDIRECT;
            // Shares its byte with the indirect jump; bit 15 tells them apart
            `ICT_OP_IND_JUMP:
                cls_o = word_i[15] ? ICT_C_TWO_WORD : ICT_C_INDIRECT;
            `ICT_OP_TBL_RD: cls_o = ICT_C_TABLE;
            `ICT_OP_TBL_WR: cls_o = ICT_C_TABLE;
            `ICT_OP_RETURN: cls_o = ICT_C_RETURN;
            `ICT_OP_RET_INT: cls_o = ICT_C_RET_INT;
            `ICT_OP_SKIP: cls_o = ICT_C_SKIP;
            `ICT_OP_TWO_GOTO: cls_o = ICT_C_TWO_WORD;
            `ICT_OP_DOUBLE_MOVE: cls_o = ICT_C_DOUBLE_MOVE;
            default: cls_o = ICT_C_SINGLE;
        endcase
    end

endmodule // ict_decode

// ---- rtl/ict_timing.sv ----
// Instruction cycle sequencer: words in, one retire pulse per instruction
`timescale 1ns/1ps
`include "ict_regs.svh"

module ict_timing
    import ict_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic word_valid_i,
    input wire logic [23:0] word_i,
    input wire logic cond_true_i,
    input wire logic pc_change_i,
    output logic word_ready_o,
    output logic exec_valid_o,
    output logic exec_nop_o,
    output logic exec_bad_o,
    output logic [3:0] exec_class_o,
    output logic [1:0] exec_cycles_o,
    output logic [23:0] exec_op_o,
    output logic [23:0] exec_operand_o
);

    ict_core_t r;
    ict_core_t next_r;
    ict_class_t cls_w;
    logic take;

    function automatic logic ict_upper_zero(input logic [23:0] w);
        return w[`ICT_OPB_HI:`ICT_OPB_LO] == `ICT_EXT_ZERO;
    endfunction

    function automatic logic [1:0] ict_flow_cycles(input ict_class_t c);
        case (c)
            ICT_C_BRANCH: return `ICT_CYC_BRANCH;
            ICT_C_INDIRECT: return `ICT_CYC_INDIRECT;
            ICT_C_TABLE: return `ICT_CYC_TABLE;
            ICT_C_RETURN: return `ICT_CYC_RETURN;
            ICT_C_RET_INT: return `ICT_CYC_RET_INT;
            ICT_C_DOUBLE_MOVE: return `ICT_CYC_DOUBLE_MOVE;
            ICT_C_COND: return `ICT_CYC_COND;
            default: return `ICT_CYC_SINGLE;
        endcase
    endfunction

    ict_decode u_decode (
        .word_i(word_i),
        .cls_o(cls_w)
    );

    assign take = word_valid_i && r.ready;

    always_comb begin
        next_r = r;
        next_r.valid = 1'b0;
        next_r.nop = 1'b0;
        next_r.bad = 1'b0;
        case (r.state)
            ICT_S_EXEC: begin
                if (take) begin
                    next_r.op = word_i;
                    next_r.ext = '0;
                    next_r.cls = cls_w;
                    next_r.cyc = 2'd1;
                    case (cls_w)
                        ICT_C_EXT: begin
                            // No state touched, only the retire marker
                            next_r.valid = 1'b1;
                            next_r.nop = 1'b1;
                        end
                        ICT_C_SINGLE: begin
                            if (pc_change_i) begin
                                next_r.left = `ICT_CYC_COND - 2'd1;
                                next_r.state = ICT_S_NOP;
                            end else begin
                                next_r.valid = 1'b1;
                            end
                        end
                        ICT_C_COND: begin
                            if (cond_true_i || pc_change_i) begin
                                next_r.left = `ICT_CYC_COND - 2'd1;
                                next_r.state = ICT_S_NOP;
                            end else begin
                                next_r.valid = 1'b1;
                            end
                        end
                        ICT_C_SKIP: begin
                            if (cond_true_i) begin
                                next_r.state = ICT_S_SKIP;
                            end else begin
                                next_r.valid = 1'b1;
                            end
                        end
                        ICT_C_TWO_WORD: begin
                            next_r.state = ICT_S_EXT;
                        end
                        default: begin
                            // Flow, table, return and double move
                            next_r.left = ict_flow_cycles(cls_w) - 2'd1;
                            next_r.state = ICT_S_NOP;
                        end
                    endcase
                end
            end
            ICT_S_EXT: begin
                if (take) begin
                    next_r.ext = word_i;
                    next_r.bad = !ict_upper_zero(word_i);
                    next_r.cyc = `ICT_CYC_TWO_WORD;
                    next_r.valid = 1'b1;
                    next_r.state = ICT_S_EXEC;
                end
            end
            ICT_S_SKIP: begin
                // Skipped word is consumed but never executed
                if (take) begin
                    next_r.ext = word_i;
                    if (cls_w == ICT_C_TWO_WORD) begin
                        next_r.state = ICT_S_SKIP_EXT;
                    end else begin
                        next_r.cyc = `ICT_CYC_SKIP_ONE;
                        next_r.valid = 1'b1;
                        next_r.state = ICT_S_EXEC;
                    end
                end
            end
            ICT_S_SKIP_EXT: begin
                if (take) begin
                    next_r.cyc = `ICT_CYC_SKIP_TWO;
                    next_r.valid = 1'b1;
                    next_r.state = ICT_S_EXEC;
                end
            end
            ICT_S_NOP: begin
                // Bubble cycles never fetch, so memory sees a stall
                next_r.cyc = r.cyc + 2'd1;
                next_r.left = r.left - 2'd1;
                if (r.left == 2'd1) begin
                    next_r.valid = 1'b1;
                    next_r.state = ICT_S_EXEC;
                end
            end
            default: begin
                next_r.state = ICT_S_EXEC;
            end
        endcase
        next_r.ready = (next_r.state != ICT_S_NOP);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '{state: ICT_S_EXEC, left: 2'd0, cyc: 2'd0, ready: 1'b0,
                   valid: 1'b0, nop: 1'b0, bad: 1'b0, cls: ICT_C_SINGLE,
                   op: 24'h000000, ext: 24'h000000};
        end else begin
            r <= next_r;
        end
    end

    assign word_ready_o = r.ready;
    assign exec_valid_o = r.valid;
    assign exec_nop_o = r.nop;
    assign exec_bad_o = r.bad;
    assign exec_class_o = r.cls;
    assign exec_cycles_o = r.cyc;
    assign exec_op_o = r.op;
    assign exec_operand_o = r.ext;

    logic in_exec;
    logic in_skip;

    assign in_exec = take && (r.state == ICT_S_EXEC);
    assign in_skip = take && (r.state == ICT_S_SKIP);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_TWO_WORD_SPAN: assert property (
        in_exec && cls_w == ICT_C_TWO_WORD ##1 take |=>
            exec_valid_o && exec_operand_o == $past(word_i)
    ) else $error("Second word not carried as operand");

    AST_EXT_UPPER: assert property (
        exec_valid_o && exec_class_o == ICT_C_TWO_WORD |->
            exec_bad_o == (exec_operand_o[23:16] != 8'h00)
    ) else $error("Second word upper byte check wrong");

    AST_LONE_EXT_NOP: assert property (
        in_exec && word_i[23:16] == 8'h00 |=>
            exec_valid_o && exec_nop_o && exec_cycles_o == 2'd1
    ) else $error("Lone second word not a one-cycle no-op");

    AST_TWO_WORD_CYC: assert property (
        exec_valid_o && exec_class_o == ICT_C_TWO_WORD |->
            exec_cycles_o == 2'd2
    ) else $error("Two-word instruction not two cycles");

    AST_SINGLE_ONE: assert property (
        in_exec && cls_w == ICT_C_SINGLE && !pc_change_i |=>
            exec_valid_o && exec_cycles_o == 2'd1
    ) else $error("Plain single-word not one cycle");

    AST_COND_TAKEN: assert property (
        in_exec && cls_w == ICT_C_COND && cond_true_i |=>
            !word_ready_o && !exec_valid_o ##1
            exec_valid_o && exec_cycles_o == 2'd2
    ) else $error("Taken conditional not two cycles");

    AST_RETURN_THREE: assert property (
        in_exec && (cls_w == ICT_C_RETURN || cls_w == ICT_C_RET_INT) |=>
            !exec_valid_o [*2] ##1 exec_valid_o && exec_cycles_o == 2'd3
    ) else $error("Return not three cycles");

    AST_BRANCH_TWO: assert property (
        in_exec && cls_w == ICT_C_BRANCH |-> ##2
            exec_valid_o && exec_cycles_o == 2'd2
    ) else $error("Branch not two cycles");

    AST_SKIP_ONE_WORD: assert property (
        in_skip && cls_w != ICT_C_TWO_WORD |=>
            exec_valid_o && exec_cycles_o == 2'd2
    ) else $error("Skip over one word not two cycles");

    AST_SKIP_TWO_WORD: assert property (
        exec_valid_o && $past(r.state) == ICT_S_SKIP_EXT |->
            exec_cycles_o == 2'd3
    ) else $error("Skip over two words not three cycles");

    AST_DMOVE_TWO: assert property (
        in_exec && cls_w == ICT_C_DOUBLE_MOVE |-> ##2
            exec_valid_o && exec_cycles_o == 2'd2
    ) else $error("Double move not two cycles");

    AST_SKIP_UNTAKEN: assert property (
        in_exec && cls_w == ICT_C_SKIP && !cond_true_i |=>
            exec_valid_o && exec_cycles_o == 2'd1
    ) else $error("Untaken skip not one cycle");

    COV_SKIP_TWO: cover property (exec_valid_o && exec_cycles_o == 2'd3 &&
        exec_class_o == ICT_C_SKIP);
    COV_TWO_WORD: cover property (exec_valid_o &&
        exec_class_o == ICT_C_TWO_WORD);
    COV_LONE_EXT: cover property (exec_valid_o && exec_nop_o);
    COV_RET_INT: cover property (exec_valid_o &&
        exec_class_o == ICT_C_RET_INT);

endmodule // ict_timing

// ---- verification/ict_prog_mem.sv ----
// Program memory model that offers instruction words to the core
`timescale 1ns/1ps
module ict_prog_mem (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic restart_i,
    input wire logic stall_i,
    input wire logic word_ready_i,
    output logic word_valid_o,
    output logic [23:0] word_o,
    output logic cond_true_o,
    output logic pc_change_o
);
    // Entry: present, condition, pc change, word
    logic [26:0] mem [0:7];
    logic [2:0] ptr;
    logic [2:0] nptr;
    logic take;

    assign take = word_valid_o && word_ready_i;
    assign nptr = restart_i ? 3'h0 : ptr + {2'h0, take};

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr <= 3'h0;
            word_valid_o <= 1'b0;
            {cond_true_o, pc_change_o, word_o} <= 26'h0;
        end else begin
            ptr <= nptr;
            // An offer is held until taken; stalls only start between words
            if (restart_i || !word_valid_o || take) begin
                word_valid_o <= !stall_i && mem[nptr][26];
                if (!stall_i && mem[nptr][26])
                    {cond_true_o, pc_change_o, word_o} <= mem[nptr][25:0];
                else
                    // Released lines toggle so stale values cannot pass
                    {cond_true_o, pc_change_o, word_o} <=
                        ~{cond_true_o, pc_change_o, word_o};
            end
        end
    end
endmodule // ict_prog_mem

// ---- verification/instruction_cycle_timing_tb.sv ----
// Self-checking bench for the instruction cycle sequencer
`timescale 1ns/1ps
module instruction_cycle_timing_tb;
    // Head: count, cond, pc; tail: class, cycles, nop, bad
    typedef struct packed {
        logic [1:0] n;
        logic c;
        logic p;
        logic [71:0] w;
        logic [3:0] cls;
        logic [1:0] cyc;
        logic nop;
        logic bad;
    } ict_row_t;
    ict_row_t rows [0:19];
    ict_row_t extra;
    logic clk, rst_n, restart, stall, wv, cond, pc, ready, ev, nop, bad;
    logic [3:0] cls;
    logic [1:0] cyc;
    logic [23:0] word, op, opd;
    int n_fail, compares, k, hits, last;

    ict_timing u_ict_timing (.clk_i(clk), .rst_n_i(rst_n),
        .word_valid_i(wv), .word_i(word), .cond_true_i(cond),
        .pc_change_i(pc), .word_ready_o(ready), .exec_valid_o(ev),
        .exec_nop_o(nop), .exec_bad_o(bad), .exec_class_o(cls),
        .exec_cycles_o(cyc), .exec_op_o(op), .exec_operand_o(opd));
    ict_prog_mem u_ict_prog_mem (.clk_i(clk), .rst_n_i(rst_n),
        .restart_i(restart), .stall_i(stall), .word_ready_i(ready),
        .word_valid_o(wv), .word_o(word), .cond_true_o(cond),
        .pc_change_o(pc));

    always #10 clk = ~clk;

    task automatic final_report();
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic start(input ict_row_t r);
        for (int i = 0; i < 8; i++)
            u_ict_prog_mem.mem[i] = (i < r.n) ? {1'b1, r.c && i == 0,
                r.p && i == 0, r.w[71 - 24 * i -: 24]} : 27'h0;
        restart = 1'b1;
        @(negedge clk);
        restart = 1'b0;
    endtask

    task automatic wait_ev(inout int k);
        while (ev !== 1'b1) begin
            @(negedge clk);
            k++;
            if (k > 40) begin
                n_fail++;
                final_report();
            end
        end
    endtask

    task automatic check_row(input ict_row_t r);
        k = 1;
        start(r);
        wait_ev(k);
        chk("latency", 24'(1 + r.cyc), 24'(k));
        chk("cycles", 24'(r.cyc), 24'(cyc));
        chk("class", 24'(r.cls), 24'(cls));
        chk("nop", 24'(r.nop), 24'(nop));
        chk("bad", 24'(r.bad), 24'(bad));
        chk("op", r.w[71:48], op);
        if (r.cls == 4'h9 || (r.cls == 4'h8 && r.cyc == 2'h2))
            chk("operand", r.w[47:24], opd);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        restart = 1'b0;
        stall = 1'b0;
        n_fail = 0;
        compares = 0;
        for (int i = 0; i < 8; i++)
            u_ict_prog_mem.mem[i] = 27'h0;
        rows[0] = {4'h4, 24'h401234, 48'h0, 8'h14};
        rows[1] = {4'h5, 24'h401234, 48'h0, 8'h18};
        rows[2] = {4'h4, 24'h310010, 48'h0, 8'h24};
        rows[3] = {4'h6, 24'h310010, 48'h0, 8'h28};
        rows[4] = {4'h4, 24'h370100, 48'h0, 8'h38};
        rows[5] = {4'h4, 24'h010002, 48'h0, 8'h48};
        rows[6] = {4'h4, 24'h020000, 48'h0, 8'h48};
        rows[7] = {4'h4, 24'hba0000, 48'h0, 8'h58};
        rows[8] = {4'h4, 24'hbb0000, 48'h0, 8'h58};
        rows[9] = {4'h4, 24'h060000, 48'h0, 8'h6c};
        rows[10] = {4'h4, 24'h070000, 48'h0, 8'h7c};
        rows[11] = {4'h4, 24'hbe0000, 48'h0, 8'ha8};
        rows[12] = {4'h8, 24'h041000, 24'h0000aa, 24'h0, 8'h98};
        rows[13] = {4'h8, 24'h028000, 24'h000055, 24'h0, 8'h98};
        rows[14] = {4'h8, 24'h041000, 24'h5a0001, 24'h0, 8'h99};
        rows[15] = {4'h4, 24'h001234, 48'h0, 8'h06};
        rows[16] = {4'h4, 24'ha60000, 48'h0, 8'h84};
        rows[17] = {4'ha, 24'ha60000, 24'h400001, 24'h0, 8'h88};
        rows[18] = {4'he, 24'ha60000, 24'h042000, 24'h000077, 8'h8c};
        rows[19] = {4'h5, 24'h310010, 48'h0, 8'h28};
        extra = {4'hc, 24'h370000, 24'h400001, 24'h060000, 8'h6c};
        repeat (3) @(negedge clk);
        chk("ready in reset", 24'h0, 24'(ready));
        rst_n = 1'b1;
        @(negedge clk);
        chk("ready after reset", 24'h1, 24'(ready));
        for (int i = 0; i < 20; i++)
            check_row(rows[i]);
        // Memory stalls between the two words must not add cycles
        start(rows[12]);
        stall = 1'b1;
        repeat (3) @(negedge clk);
        stall = 1'b0;
        k = 4;
        wait_ev(k);
        chk("stalled latency", 24'h6, 24'(k));
        chk("stalled cycles", 24'h2, 24'(cyc));
        chk("stalled operand", 24'h0000aa, opd);
        // Back to back: branch, single, return
        start(extra);
        k = 1;
        hits = 0;
        while (k < 12) begin
            if (ev === 1'b1) begin
                hits++;
                last = k;
            end
            @(negedge clk);
            k++;
        end
        chk("retire count", 24'h3, 24'(hits));
        chk("last retire", 24'h7, 24'(last));
        chk("last class", 24'h6, 24'(cls));
        // Reset in mid instruction abandons it
        start(rows[9]);
        @(negedge clk);
        chk("ready in bubble", 24'h0, 24'(ready));
        rst_n = 1'b0;
        // Empty memory so no stale word is offered after release
        for (int i = 0; i < 8; i++)
            u_ict_prog_mem.mem[i] = 27'h0;
        @(negedge clk);
        chk("retire in reset", 24'h0, 24'(ev));
        chk("ready in mid reset", 24'h0, 24'(ready));
        rst_n = 1'b1;
        @(negedge clk);
        check_row(rows[0]);
        final_report();
    end
endmodule // instruction_cycle_timing_tb
